/* bench/four_channel_pwm_core_bench.sv */
`timescale 1ns/1ns
`include "pwm_core_consts.svh"
module four_channel_pwm_core_bench;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] gd = 4'h0;
	logic [3:0] gdir = 4'h0;
	logic [3:0] port;
	logic [3:0] oe_n;
	logic [33:0] notes[$];
	logic [33:0] note;
	logic [31:0] rd;
	logic [7:0] v;
	int errors = 0;
	int num_checks = 0;
	int h;

	four_channel_pwm_core i_four_channel_pwm_core (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .gpio_data_i(gd), .gpio_dir_i(gdir), .port_o(port), .port_oe_n_o(oe_n)
	);

	// Clock of 10 ns
	initial begin
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	// ==========================================
	// Checks and bus tasks
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d, mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// One transfer; holds everything until pready is seen, then idles one cycle
	task automatic apb(input logic [9:0] idx, input logic wr, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge clk_sys_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys_i);
		end while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic err = 1'b0);
		notes.push_back({1'b0, err, 32'h00000000});
		apb(idx, 1'b1, d);
	endtask

	task automatic rdc(input logic [9:0] idx, input logic [7:0] exp, input logic err = 1'b0);
		notes.push_back({1'b1, err, 24'h000000, exp});
		apb(idx, 1'b0, 8'h00);
	endtask

	task automatic rdv;
		notes.push_back({1'b0, 1'b0, 32'h00000000});
		apb(`IDX_CNT_BASE, 1'b0, 8'h00);
		v = rd[7:0];
	endtask

	task automatic hi_cnt(input int b, input int n, input int exp);
		int l;
		h = 0;
		l = 0;
		repeat (n) begin
			@(posedge clk_sys_i);
			if (port[b] === 1'b1) h++;
			if (port[b] === 1'b0) l++;
		end
		check("high cycles", 32'(exp), 32'(h));
		check("low cycles", 32'(n - exp), 32'(l));
	endtask

	// Compare each completed transfer with the oldest note
	always @(posedge clk_sys_i) begin
		if (psel && penable && pready === 1'b1) begin
			note = notes.pop_front();
			check("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
			if (note[33]) begin
				check("prdata", note[31:0], prdata);
			end
		end
	end

	// Cuts a hang short
	initial begin
		repeat (40000) @(posedge clk_sys_i);
		errors++;
		stop_test();
	end

	// ==========================================
	// Tests
	initial begin
		void'($urandom(20048));
		repeat (16) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		@(posedge clk_sys_i);
		check("oe_n reset", 32'hf, {28'h0, oe_n});
		for (int i = 0; i < 6; i++) rdc(10'(`IDX_CLK_CONCAT + i), 8'h00);
		rdc(10'h03f, 8'h00, 1'b1);
		wr(10'h03f, 8'hff, 1'b1);
		$display("reset and map done");
		// Clock control register reads back at any time
		repeat (3) begin
			v = 8'($urandom);
			wr(`IDX_CLK_CONCAT, v);
			rdc(`IDX_CLK_CONCAT, v);
		end
		wr(`IDX_CLK_CONCAT, 8'h00);
		// Pins stay general I/O while no channel is enabled
		repeat (4) begin
			gd <= 4'($urandom);
			gdir <= 4'($urandom);
			repeat (3) @(posedge clk_sys_i);
			check("port", {28'h0, gd}, {28'h0, port});
			check("oe_n", {28'h0, ~gdir}, {28'h0, oe_n});
		end
		$display("gpio done");
		// Left-aligned duty and polarity, then center-aligned duty 2, period 4
		wr(`IDX_PER_BASE, 8'h04);
		rdc(`IDX_PER_BASE, 8'h04);
		wr(`IDX_ENABLE, 8'h01);
		for (int i = 0; i < 4; i++) begin
			wr(`IDX_SEL_POL, (i == 1) ? 8'h00 : 8'h01);
			wr(`IDX_DTY_BASE, (i == 2) ? 8'h00 : ((i == 3) ? 8'h04 : 8'h01));
			repeat (8) @(posedge clk_sys_i);
			check("oe_n0", 32'h0, {31'h0, oe_n[0]});
			hi_cnt(0, 40, (i == 0) ? 10 : ((i == 1) ? 30 : ((i == 2) ? 0 : 40)));
		end
		wr(`IDX_DTY_BASE, 8'h02);
		wr(`IDX_ALIGN, 8'h01);
		repeat (12) @(posedge clk_sys_i);
		hi_cnt(0, 80, 30);
		wr(`IDX_ALIGN, 8'h00);
		$display("waveform done");
		// Buffered duty waits; a counter write forces it in
		wr(`IDX_PER_BASE, 8'hfa);
		wr(`IDX_DTY_BASE, 8'h00);
		wr(`IDX_CNT_BASE, 8'h00);
		repeat (4) @(posedge clk_sys_i);
		hi_cnt(0, 100, 0);
		wr(`IDX_DTY_BASE, 8'hff);
		hi_cnt(0, 60, 0);
		rdc(`IDX_DTY_BASE, 8'hff);
		rdv();
		check("count mid", 32'h1, 32'(v > 8'd150 && v < 8'd200));
		wr(`IDX_CNT_BASE, 8'h00);
		rdv();
		check("count cleared", 32'h1, 32'(v < 8'd6));
		hi_cnt(0, 40, 40);
		// Clock enable low freezes the counter
		rdv();
		h = v;
		ce <= 1'b0;
		repeat (50) @(posedge clk_sys_i);
		ce <= 1'b1;
		rdv();
		check("frozen count", 32'h1, 32'(v - 8'(h) < 8'd8));
		$display("buffering done");
		// Clock A divide codes, counter pace over 32 ticks
		wr(`IDX_PER_BASE, 8'hff);
		for (int n = 0; n < 8; n++) begin
			wr(`IDX_CLK_CONCAT, 8'((n << `CLKA_SEL_LSB) | (n << `CLKB_SEL_LSB)));
			wr(`IDX_CNT_BASE, 8'h00);
			repeat (32 << n) @(posedge clk_sys_i);
			rdv();
			check("divided count", 32'h1, 32'(v >= 8'd31 && v <= 8'd35));
		end
		// Scaled clock S0: clock A divided by (scale + 1) * 2
		wr(`IDX_CLK_CONCAT, 8'h00);
		wr(`IDX_SCALE0, 8'h03);
		wr(`IDX_SEL_POL, 8'h11);
		wr(`IDX_CNT_BASE, 8'h00);
		repeat (256) @(posedge clk_sys_i);
		rdv();
		check("scaled count", 32'h1, 32'(v >= 8'd31 && v <= 8'd35));
		$display("prescale done");
		// Joined pairs: 16-bit period 0x0200, duty 0x0100
		for (int p = 0; p < 2; p++) begin
			wr(`IDX_CLK_CONCAT, (p == 1) ? 8'h80 : 8'h40);
			wr(`IDX_SEL_POL, 8'(1 << (2 * p)));
			wr(10'(`IDX_PER_BASE + 2 * p), 8'h02);
			wr(10'(`IDX_PER_BASE + 2 * p + 1), 8'h00);
			wr(10'(`IDX_DTY_BASE + 2 * p), 8'h01);
			wr(10'(`IDX_DTY_BASE + 2 * p + 1), 8'h00);
			wr(`IDX_ENABLE, 8'(3 << (2 * p)));
			wr(10'(`IDX_CNT_BASE + 2 * p), 8'h00);
			repeat (4) @(posedge clk_sys_i);
			hi_cnt(2 * p, 1024, 512);
			check("odd pin oe_n", {31'h0, ~gdir[2 * p + 1]}, {31'h0, oe_n[2 * p + 1]});
			check("odd pin", {31'h0, gd[2 * p + 1]}, {31'h0, port[2 * p + 1]});
			wr(`IDX_ENABLE, 8'h00);
		end
		$display("join done");
		stop_test();
	end
endmodule

/* design/four_channel_pwm_core.sv */
`timescale 1ns/1ns
`include "pwm_core_consts.svh"
module four_channel_pwm_core #(
	parameter int ADDR_W = 12
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [3:0] gpio_data_i,
	input wire logic [3:0] gpio_dir_i,
	output logic [3:0] port_o,
	output logic [3:0] port_oe_n_o
);
	// ==========================================================
	// Register state
	pwm_core_pkg::byte_type clock_concat_control, sel_pol, chan_en, align_ctrl;
	pwm_core_pkg::byte_type scale0, scale1, scnt0, scnt1;
	pwm_core_pkg::byte_type cnt [4];
	pwm_core_pkg::byte_type buf_per [4];
	pwm_core_pkg::byte_type buf_dty [4];
	pwm_core_pkg::byte_type act_per [4];
	pwm_core_pkg::byte_type act_dty [4];
	pwm_core_pkg::byte_type next_per [4];
	pwm_core_pkg::byte_type next_dty [4];
	pwm_core_pkg::wide_type nxt16 [4];
	logic [1:0] ctl [4];
	logic [1:0] csel [4];
	logic [6:0] prescale;
	logic [3:0] dir_down, next_down, roll, step, lvl, own, wide_v, clr, load, cnt_wr;
	logic half0, half1;
	logic [9:0] idx;
	logic wr_en, mapped;
	logic [7:0] next_rdata;
	logic any_en, tick_a, tick_b, tick_s0, tick_s1;
	logic [6:0] mask_a, mask_b;
	logic [2:0] div_a, div_b;

	// APB decode; a write lands at the access edge with pready high
	assign idx = paddr_i[11:2];
	assign wr_en = psel_i && penable_i && pwrite_i && pready_o && ce_i;
	assign div_a = clock_concat_control[`CLKA_SEL_LSB +: 3];
	assign div_b = clock_concat_control[`CLKB_SEL_LSB +: 3];

	// ==========================================================
	// Prescaler and scaled clocks
	assign any_en = |chan_en[3:0];
	assign mask_a = 7'(~(8'hff << div_a));
	assign mask_b = 7'(~(8'hff << div_b));
	assign tick_a = any_en && ((prescale & mask_a) == mask_a);
	assign tick_b = any_en && ((prescale & mask_b) == mask_b);
	assign tick_s0 = tick_a && (scnt0 == 8'h00) && half0;
	assign tick_s1 = tick_b && (scnt1 == 8'h00) && half1;

	// Free-running prescaler, stopped while every channel is off
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			prescale <= 7'h00;
		end else if (ce_i && any_en) begin
			prescale <= 7'(prescale + 7'h01);
		end
	end

	// Scale down-counters; a scale write reloads its counter
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			scnt0 <= `REG_RESET;
			scnt1 <= `REG_RESET;
			half0 <= 1'b0;
			half1 <= 1'b0;
		end else if (ce_i) begin
			if (wr_en && idx == `IDX_SCALE0) begin
				scnt0 <= pwdata_i[7:0];
			end else if (tick_a) begin
				scnt0 <= (scnt0 == 8'h00) ? scale0 : 8'(scnt0 - 8'h01);
				half0 <= (scnt0 == 8'h00) ? ~half0 : half0;
			end
			if (wr_en && idx == `IDX_SCALE1) begin
				scnt1 <= pwdata_i[7:0];
			end else if (tick_b) begin
				scnt1 <= (scnt1 == 8'h00) ? scale1 : 8'(scnt1 - 8'h01);
				half1 <= (scnt1 == 8'h00) ? ~half1 : half1;
			end
		end
	end

	// ==========================================================
	// Per-lane counting engine
	for (genvar i = 0; i < 4; i++) begin : lane
		localparam int HI = i - (i % 2);
		logic joined, wide, ltick, ll_roll, c_up_end;
		logic [16:0] up1;
		pwm_core_pkg::wide_type cur, per, dty;
		assign joined = clock_concat_control[(i < 2) ? `JOIN_LOWER_BIT : `JOIN_UPPER_BIT];
		assign wide = joined && (i % 2 == 0);
		assign wide_v[i] = wide;
		assign ctl[i] = joined ? 2'(HI) : 2'(i);
		assign csel[i] = joined ? 2'(HI + 1) : 2'(i);
		// Combined count, period and duty when the pair is joined
		assign cur = wide ? {cnt[i], cnt[HI + 1]} : {8'h00, cnt[i]};
		assign per = wide ? {act_per[i], act_per[HI + 1]} : {8'h00, act_per[i]};
		assign dty = wide ? {act_dty[i], act_dty[HI + 1]} : {8'h00, act_dty[i]};
		// Clock source: base prescaled clock or scaled clock
		assign ltick = sel_pol[4 + csel[i]] ? ((i < 2) ? tick_s0 : tick_s1)
			: ((i < 2) ? tick_a : tick_b);
		assign step[i] = ce_i && chan_en[i] && ltick;
		assign up1 = 17'(cur) + 17'h00001;
		assign ll_roll = up1 >= {1'b0, per};
		assign c_up_end = up1 >= {1'b0, per};
		// Left counts 0..per-1; center counts up to per and back to 0
		always_comb begin
			if (align_ctrl[i] == pwm_core_pkg::ALIGN_LEFT) begin
				nxt16[i] = ll_roll ? 16'h0000 : up1[15:0];
				next_down[i] = 1'b0;
				roll[i] = ll_roll;
			end else if (!dir_down[i]) begin
				nxt16[i] = up1[15:0];
				next_down[i] = c_up_end;
				roll[i] = 1'b0;
			end else begin
				nxt16[i] = (cur == 16'h0000) ? 16'h0000 : 16'(cur - 16'h0001);
				next_down[i] = cur > 16'h0001;
				roll[i] = cur <= 16'h0001;
			end
		end
		assign lvl[i] = sel_pol[i] ? (cur < dty) : (cur >= dty);
		assign own[i] = chan_en[i] && !(joined && (i % 2 == 1));
		assign cnt_wr[i] = wr_en && idx == (`IDX_CNT_BASE + 10'(i));
		assign clr[i] = !chan_en[i] || cnt_wr[i] || (wide && cnt_wr[HI + 1]);
		assign load[i] = clr[i] || (step[i] && roll[i]);
		assign next_per[i] = (wr_en && idx == (`IDX_PER_BASE + 10'(i))) ? pwdata_i[7:0] : buf_per[i];
		assign next_dty[i] = (wr_en && idx == (`IDX_DTY_BASE + 10'(i))) ? pwdata_i[7:0] : buf_dty[i];
	end

	// Counters and active latches follow their controlling lane
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			for (int i = 0; i < 4; i++) begin
				cnt[i] <= `REG_RESET;
				act_per[i] <= `REG_RESET;
				act_dty[i] <= `REG_RESET;
			end
			dir_down <= 4'h0;
		end else if (ce_i) begin
			for (int i = 0; i < 4; i++) begin
				if (clr[ctl[i]]) begin
					cnt[i] <= 8'h00;
					dir_down[i] <= 1'b0;
				end else if (step[ctl[i]]) begin
					cnt[i] <= (ctl[i] != 2'(i)) ? nxt16[ctl[i]][7:0]
						: (wide_v[i] ? nxt16[i][15:8] : nxt16[i][7:0]);
					dir_down[i] <= next_down[ctl[i]];
				end
				if (load[ctl[i]]) begin
					act_per[i] <= next_per[i];
					act_dty[i] <= next_dty[i];
				end
			end
		end
	end

	// ==========================================================
	// Software registers
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			clock_concat_control <= `REG_RESET;
			sel_pol <= `REG_RESET;
			chan_en <= `REG_RESET;
			align_ctrl <= `REG_RESET;
			scale0 <= `REG_RESET;
			scale1 <= `REG_RESET;
			for (int i = 0; i < 4; i++) begin
				buf_per[i] <= `REG_RESET;
				buf_dty[i] <= `REG_RESET;
			end
		end else if (ce_i) begin
			if (wr_en) begin
				case (idx)
					`IDX_CLK_CONCAT: clock_concat_control <= pwdata_i[7:0];
					`IDX_SEL_POL: sel_pol <= pwdata_i[7:0];
					`IDX_ENABLE: chan_en <= {4'h0, pwdata_i[3:0]};
					`IDX_ALIGN: align_ctrl <= {4'h0, pwdata_i[3:0]};
					`IDX_SCALE0: scale0 <= pwdata_i[7:0];
					`IDX_SCALE1: scale1 <= pwdata_i[7:0];
					default: begin
					end
				endcase
			end
			for (int i = 0; i < 4; i++) begin
				buf_per[i] <= next_per[i];
				buf_dty[i] <= next_dty[i];
			end
		end
	end

	// Read mux and map check
	always_comb begin
		next_rdata = 8'h00;
		mapped = 1'b1;
		case (idx)
			`IDX_CLK_CONCAT: next_rdata = clock_concat_control;
			`IDX_SEL_POL: next_rdata = sel_pol;
			`IDX_ENABLE: next_rdata = chan_en;
			`IDX_PRESCALE: next_rdata = {1'b0, prescale};
			`IDX_SCALE0: next_rdata = scale0;
			`IDX_SCNT0: next_rdata = scnt0;
			`IDX_SCALE1: next_rdata = scale1;
			`IDX_SCNT1: next_rdata = scnt1;
			`IDX_ALIGN: next_rdata = align_ctrl;
			default: begin
				if (idx[9:2] == 8'(`IDX_CNT_BASE >> 2)) begin
					next_rdata = cnt[idx[1:0]];
				end else if (idx[9:2] == 8'(`IDX_PER_BASE >> 2)) begin
					next_rdata = buf_per[idx[1:0]];
				end else if (idx[9:2] == 8'(`IDX_DTY_BASE >> 2)) begin
					next_rdata = buf_dty[idx[1:0]];
				end else begin
					mapped = 1'b0;
				end
			end
		endcase
	end

	// Zero-wait slave: answer in the first access cycle
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else if (ce_i) begin
			pready_o <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && !mapped;
			if (psel_i && !penable_i) begin
				prdata_o <= {24'h00_0000, next_rdata};
			end
		end
	end

	// ==========================================================
	// Pin ownership: channel wins over the port logic
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			port_o <= 4'h0;
			port_oe_n_o <= 4'hf;
		end else if (ce_i) begin
			for (int i = 0; i < 4; i++) begin
				port_o[i] <= own[i] ? lvl[i] : gpio_data_i[i];
				port_oe_n_o[i] <= !(own[i] || gpio_dir_i[i]);
			end
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	counter_clear_a: assert property (cnt_wr[0] |=> cnt[0] == 8'h00)
		else $error("counter write did not clear");
	disabled_latch_a: assert property (!chan_en[0] && wr_en && idx == `IDX_PER_BASE
		|=> act_per[0] == $past(pwdata_i[7:0]))
		else $error("disabled period write missed latch");
	enabled_hold_a: assert property (ce_i && chan_en[0] && !load[0] && !wide_v[0]
		|=> act_per[0] == $past(act_per[0]))
		else $error("active period changed without load");
	pin_override_a: assert property (ce_i && own[2] |=> !port_oe_n_o[2])
		else $error("enabled channel lost its pin");
	upper_join_a: assert property (ce_i && clock_concat_control[`JOIN_UPPER_BIT]
		|=> port_o[3] == $past(gpio_data_i[3]))
		else $error("joined upper pair kept pin 3");
	lower_join_a: assert property (ce_i && clock_concat_control[`JOIN_LOWER_BIT]
		|=> port_o[1] == $past(gpio_data_i[1]))
		else $error("joined lower pair kept pin 1");
	prescale_rate_a: assert property (tick_a && div_a == 3'h3 |-> prescale[2:0] == 3'h7)
		else $error("clock A tick off its divide");
	left_start_a: assert property (ce_i && chan_en[0] && !wide_v[0] && !align_ctrl[0]
		&& cnt[0] == 8'h00 && act_dty[0] != 8'h00 |=> port_o[0] == $past(sel_pol[0]))
		else $error("period start level wrong");
	left_roll_a: assert property (step[0] && !clr[0] && !wide_v[0] && !align_ctrl[0]
		&& act_per[0] != 8'h00 && 9'(cnt[0]) + 9'h001 >= {1'b0, act_per[0]} |=> cnt[0] == 8'h00)
		else $error("counter missed rollover");
	wide_count_a: assert property (step[0] && wide_v[0] && !clr[0] && !roll[0] && !dir_down[0]
		&& cnt[1] == 8'hff |=> cnt[0] == 8'($past(cnt[0]) + 8'h01))
		else $error("joined carry lost");

	center_turn_a: assert property (step[0] && !clr[0] && !wide_v[0] && align_ctrl[0] && dir_down[0]
		&& cnt[0] == 8'h01 |=> cnt[0] == 8'h00 && !dir_down[0])
		else $error("center count missed its turn");
	prescale_b_a: assert property (tick_b && div_b == 3'h7 |-> prescale == 7'h7f)
		else $error("clock B tick off its divide");

	// Main scenarios the bench should reach
	join_cov: cover property (wide_v[0] && step[0] && roll[0]);
	center_cov: cover property (align_ctrl[2] && dir_down[2] && step[2]);
	cnt_write_cov: cover property (cnt_wr[1] && chan_en[1]);
	scaled_cov: cover property (step[0] && sel_pol[4]);
	upper_join_cov: cover property (wide_v[2] && step[2] && roll[2]);
endmodule

/* inc/pwm_core_consts.svh */
`ifndef PWM_CORE_CONSTS_SVH
`define PWM_CORE_CONSTS_SVH
// What this block does
// - Four 8-bit channels, two 16-bit, or one 16-bit plus two 8-bit.
// - Each channel owns its period value, duty value and counter.
// - Counters clock from one of two sources chosen per channel: A or S0 for 0 and 1, B or S1 for 2 and 3.
// - Duty ratio settable anywhere from 0 to 100 percent.
// - Pulses are left-aligned or center-aligned per channel.
// - Writes while enabled wait in a buffer until rollover or disable.
// - Writes while disabled reach buffer and active latch together.
// - Writing a counter clears it and latches pending period and duty.
// - Software can read each channel counter.
// - Enabled channel drives its pin, except the low-byte channel of a joined pair; unused pins stay general I/O.
// - Joined upper pair: 2 high byte, 3 low, pin 2, channel 3 clock select.
// - Joined lower pair: 0 high byte, 1 low, pin 0, channel 1 clock select.
// - Three-bit field sets clock A rate for channels 0 and 1.
// - Prescale code n divides the prescaler input by two to the n.
// - Left-aligned polarity 0 starts low, 1 starts high; flips at duty.

// Register indexes; byte address is four times the index
`define IDX_CLK_CONCAT 10'h040
`define IDX_SEL_POL 10'h041
`define IDX_ENABLE 10'h042
`define IDX_PRESCALE 10'h043
`define IDX_SCALE0 10'h044
`define IDX_SCNT0 10'h045
`define IDX_SCALE1 10'h046
`define IDX_SCNT1 10'h047
`define IDX_ALIGN 10'h048
`define IDX_CNT_BASE 10'h04c
`define IDX_PER_BASE 10'h050
`define IDX_DTY_BASE 10'h054

// Field positions
`define JOIN_UPPER_BIT 7
`define JOIN_LOWER_BIT 6
`define CLKA_SEL_LSB 3
`define CLKB_SEL_LSB 0
`define REG_RESET 8'h00
`endif

/* inc/pwm_core_pkg.sv */
package pwm_core_pkg;
	typedef logic [7:0] byte_type;
	typedef logic [15:0] wide_type;
	typedef enum logic {ALIGN_LEFT = 1'b0, ALIGN_CENTER = 1'b1} align_type;
endpackage
